/* src/bridge_memory_window_regs.sv */
// Memory and I/O window registers of a two-port bus bridge, with the address decode that uses them.
// Assumes a register master on the same clock, reads answered one cycle later, and queries from local logic.
// Assumes the lower I/O bounds and the forwarding datapath itself sit in neighbouring logic.
//
// Summary of operation
// [R01] The non-prefetchable bottom field in bits 15:4 gives address bits 31:20, low 20 bits zero, reset zero.
// [R02] The non-prefetchable top field in bits 31:20 gives address bits 31:20, low 20 bits all ones.
// [R03] The non-prefetchable pair decides whether a memory transaction crosses to the other side.
// [R04] The low nibble of both prefetchable halfwords reads 0001 for 64-bit capability and ignores writes.
// [R05] The prefetchable bottom field in bits 15:4 gives address bits 31:20, low 20 bits zero, and steers forwarding.
// [R06] The prefetchable bottom upper word forms bits 63:32 of the 64-bit window bottom.
// [R07] The prefetchable top field in bits 31:20 gives bits 31:20 with low bits ones, its upper word bits 63:32.
// [R08] A fully writable 32-bit word holds bits 63:32 of the prefetchable bottom and resets to zero.
// [R09] A fully writable 32-bit word holds bits 63:32 of the prefetchable top and resets to zero.
// [R10] A 16-bit field in bits 15:0 gives bits 31:16 of the I/O window bottom and resets to zero.
// [R11] A 16-bit field in bits 31:16 of the same word gives bits 31:16 of the I/O window top and resets to zero.
// [R12] An address is inside a window when it is at or above the bottom and at or below the top.
// [R13] Reserved bits 3:0 and 19:16 of the non-prefetchable word read zero and ignore writes.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`include "bridge_window_defs.svh"

module bridge_memory_window_regs (
	input  wire logic                        core_clk_in,
	input  wire logic                        rst_in,
	// Register port, on the same clock as the bank.
	input  wire logic [`REG_ADDR_W-1:0]      reg_addr_in,
	input  wire logic [31:0]                 reg_wdata_in,
	input  wire logic                        reg_wr_in,
	input  wire logic                        reg_rd_in,
	output logic      [31:0]                 reg_rdata_out,
	// Decode query port, driven by the local forwarding logic.
	input  wire logic                        qry_valid_in,
	input  wire logic                        qry_space_in,
	input  wire logic                        qry_from_secondary_in,
	input  wire logic [63:0]                 qry_addr_in,
	output logic                             qry_done_out,
	output logic                             hit_nonpref_out,
	output logic                             hit_pref_out,
	output logic                             hit_io_out,
	output logic                             forward_out
);

	// Write strobes of each register word.
	logic                        wr_mem_window;
	logic                        wr_pref_low;
	logic                        wr_pref_bottom_hi;
	logic                        wr_pref_top_hi;
	logic                        wr_io_window;

	// Stored fields.
	logic [`MEM_FIELD_W-1:0]     nonpref_bottom;
	logic [`MEM_FIELD_W-1:0]     nonpref_top;
	logic [`MEM_FIELD_W-1:0]     pref_bottom_low;
	logic [`MEM_FIELD_W-1:0]     pref_top_low;
	logic [`HIGH_WORD_W-1:0]     pref_bottom_high;
	logic [`HIGH_WORD_W-1:0]     pref_top_high;
	logic [`IO_FIELD_W-1:0]      io_bottom_high;
	logic [`IO_FIELD_W-1:0]      io_top_high;

	// Expanded window bounds.
	logic [31:0]                 nonpref_lo_addr;
	logic [31:0]                 nonpref_hi_addr;
	logic [63:0]                 pref_lo_addr;
	logic [63:0]                 pref_hi_addr;

	// Raw compare results.
	logic                        in_nonpref_raw;
	logic                        in_pref_raw;
	logic                        in_io_raw;
	logic                        upper_zero;

	// Qualified decode results.
	logic                        nxt_hit_nonpref;
	logic                        nxt_hit_pref;
	logic                        nxt_hit_io;
	logic                        nxt_forward;

	// Registered outputs.
	logic [31:0]                 nxt_rdata;
	logic [31:0]                 rdata_ff;
	logic                        qry_done_ff;
	logic                        hit_nonpref_ff;
	logic                        hit_pref_ff;
	logic                        hit_io_ff;
	logic                        forward_ff;

	// Register map, one aligned 32-bit word per offset.
	// Offset 0x20 holds the non-prefetchable top in 31:20 and bottom in 15:4, with zero nibbles below each.
	// Offset 0x24 holds the prefetchable top and bottom low parts, each above the fixed 64-bit code.
	// Offsets 0x28 and 0x2C hold bits 63:32 of the prefetchable bottom and top.
	// Offset 0x30 holds bits 31:16 of the I/O top in its upper half and of the I/O bottom in its lower half.
	// There are no byte enables, so every write replaces all writable fields of its word at once.

	// Address decode of the write strobe; a write to any other offset changes nothing.
	assign wr_mem_window     = reg_wr_in && (reg_addr_in == `OFS_MEM_WINDOW);
	assign wr_pref_low       = reg_wr_in && (reg_addr_in == `OFS_PREF_WINDOW_LOW);
	assign wr_pref_bottom_hi = reg_wr_in && (reg_addr_in == `OFS_PREF_BOTTOM_HI);
	assign wr_pref_top_hi    = reg_wr_in && (reg_addr_in == `OFS_PREF_TOP_HI);
	assign wr_io_window      = reg_wr_in && (reg_addr_in == `OFS_IO_WINDOW_HI);

	// Each stored field is a small register of its own, loaded by the strobe decode above.
	// Reserved and constant nibbles have no storage at all, so writes to them are dropped by construction.

	// Non-prefetchable bottom, bits 15:4 of the word.
	window_field #(
		.WIDTH     (`MEM_FIELD_W),
		.RST_VALUE (`RST_MEM_FIELD)
	) u_nonpref_bottom (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.load_in     (wr_mem_window), // [R01]
		.data_in     (reg_wdata_in[`BASE_FIELD_MSB:`BASE_FIELD_LSB]),
		.value_out   (nonpref_bottom)
	);

	// Non-prefetchable top, bits 31:20 of the word.
	window_field #(
		.WIDTH     (`MEM_FIELD_W),
		.RST_VALUE (`RST_MEM_FIELD)
	) u_nonpref_top (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.load_in     (wr_mem_window), // [R02]
		.data_in     (reg_wdata_in[`LIMIT_FIELD_MSB:`LIMIT_FIELD_LSB]),
		.value_out   (nonpref_top)
	);

	// Prefetchable bottom, low half, bits 15:4 of the word.
	window_field #(
		.WIDTH     (`MEM_FIELD_W),
		.RST_VALUE (`RST_MEM_FIELD)
	) u_pref_bottom_low (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.load_in     (wr_pref_low), // [R05]
		.data_in     (reg_wdata_in[`BASE_FIELD_MSB:`BASE_FIELD_LSB]),
		.value_out   (pref_bottom_low)
	);

	// Prefetchable top, low half, bits 31:20 of the word.
	window_field #(
		.WIDTH     (`MEM_FIELD_W),
		.RST_VALUE (`RST_MEM_FIELD)
	) u_pref_top_low (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.load_in     (wr_pref_low), // [R07]
		.data_in     (reg_wdata_in[`LIMIT_FIELD_MSB:`LIMIT_FIELD_LSB]),
		.value_out   (pref_top_low)
	);

	// Prefetchable bottom, upper 32 bits.
	window_field #(
		.WIDTH     (`HIGH_WORD_W),
		.RST_VALUE (`RST_HIGH_WORD)
	) u_pref_bottom_high (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.load_in     (wr_pref_bottom_hi), // [R08]
		.data_in     (reg_wdata_in),
		.value_out   (pref_bottom_high)
	);

	// Prefetchable top, upper 32 bits.
	window_field #(
		.WIDTH     (`HIGH_WORD_W),
		.RST_VALUE (`RST_HIGH_WORD)
	) u_pref_top_high (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.load_in     (wr_pref_top_hi), // [R09]
		.data_in     (reg_wdata_in),
		.value_out   (pref_top_high)
	);

	// I/O bottom, upper 16 bits, in the low half of its word.
	window_field #(
		.WIDTH     (`IO_FIELD_W),
		.RST_VALUE (`RST_IO_FIELD)
	) u_io_bottom_high (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.load_in     (wr_io_window), // [R10]
		.data_in     (reg_wdata_in[`IO_BOTTOM_MSB:`IO_BOTTOM_LSB]),
		.value_out   (io_bottom_high)
	);

	// I/O top, upper 16 bits, in the high half of the same word.
	window_field #(
		.WIDTH     (`IO_FIELD_W),
		.RST_VALUE (`RST_IO_FIELD)
	) u_io_top_high (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.load_in     (wr_io_window), // [R11]
		.data_in     (reg_wdata_in[`IO_TOP_MSB:`IO_TOP_LSB]),
		.value_out   (io_top_high)
	);

	// Widen the stored fields with their implied low bits: zeros below a bottom, ones below a top.
	// A bottom above its top leaves the window empty, which is how software switches a window off.
	assign nonpref_lo_addr = {nonpref_bottom, `LOW20_BOTTOM}; // [R01]
	assign nonpref_hi_addr = {nonpref_top, `LOW20_TOP}; // [R02]
	assign pref_lo_addr    = {pref_bottom_high, pref_bottom_low, `LOW20_BOTTOM}; // [R06]
	assign pref_hi_addr    = {pref_top_high, pref_top_low, `LOW20_TOP}; // [R07]

	// Queries come from logic on this clock, so no synchroniser sits in front of the compares.
	// The non-prefetchable window lives below 4 GB, so any upper address bit set means a miss.
	assign upper_zero = (qry_addr_in[63:32] == `UPPER32_ZERO);

	// The three range checks run every cycle; only the registered results below leave the block.

	// Non-prefetchable range check on the low 32 address bits.
	window_compare #(
		.WIDTH (32)
	) u_cmp_nonpref (
		.addr_in    (qry_addr_in[31:0]),
		.bottom_in  (nonpref_lo_addr),
		.top_in     (nonpref_hi_addr),
		.inside_out (in_nonpref_raw)
	);

	// Prefetchable range check on the full 64-bit address.
	window_compare #(
		.WIDTH (64)
	) u_cmp_pref (
		.addr_in    (qry_addr_in),
		.bottom_in  (pref_lo_addr),
		.top_in     (pref_hi_addr),
		.inside_out (in_pref_raw)
	);

	// I/O range check on address bits 31:16 only; the lower I/O bounds are kept elsewhere.
	window_compare #(
		.WIDTH (`IO_FIELD_W)
	) u_cmp_io (
		.addr_in    (qry_addr_in[31:16]),
		.bottom_in  (io_bottom_high),
		.top_in     (io_top_high),
		.inside_out (in_io_raw)
	);

	// Qualify the raw compares by address space and decide whether the transaction crosses.
	always_comb begin
		nxt_hit_nonpref = 1'h0;
		nxt_hit_pref    = 1'h0;
		nxt_hit_io      = 1'h0;
		nxt_forward     = 1'h0;
		case (bridge_window_pkg::space_t'(qry_space_in))
			bridge_window_pkg::SPACE_MEMORY: begin
				// The 32-bit window also needs a zero upper half; the 64-bit window compares every bit.
				nxt_hit_nonpref = in_nonpref_raw && upper_zero; // [R03]
				nxt_hit_pref    = in_pref_raw; // [R05]
			end
			bridge_window_pkg::SPACE_IO: begin
				// The I/O window is 32 bits wide, so an address above 4 GB never hits it.
				nxt_hit_io = in_io_raw && upper_zero; // [R10]
			end
			default: begin
				// A one-bit space code cannot reach here; the branch keeps every path assigned.
				nxt_hit_io = 1'h0;
			end
		endcase
		// Downstream traffic crosses when it hits a window, upstream traffic when it misses all of them.
		// The direction only flips the sense of the decision, never the window hits themselves.
		if (qry_from_secondary_in) begin
			nxt_forward = !(nxt_hit_nonpref || nxt_hit_pref || nxt_hit_io); // [R03]
		end else begin
			nxt_forward = nxt_hit_nonpref || nxt_hit_pref || nxt_hit_io; // [R03]
		end
	end

	// Decode results are registered so the forwarding logic sees a clean one-cycle answer.
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			qry_done_ff    <= 1'h0;
			hit_nonpref_ff <= 1'h0;
			hit_pref_ff    <= 1'h0;
			hit_io_ff      <= 1'h0;
			forward_ff     <= 1'h0;
		end else begin
			qry_done_ff <= qry_valid_in;
			// Hits load only on a query, so they hold for the forwarding logic between queries.
			if (qry_valid_in) begin
				hit_nonpref_ff <= nxt_hit_nonpref;
				hit_pref_ff    <= nxt_hit_pref;
				hit_io_ff      <= nxt_hit_io;
				forward_ff     <= nxt_forward;
			end
		end
	end

	// Read data mux; reserved nibbles read zero and the 64-bit code is a constant, so writes cannot touch them.
	always_comb begin
		nxt_rdata = `READ_IDLE;
		case (reg_addr_in)
			// Non-prefetchable pair with its zero nibbles.
			`OFS_MEM_WINDOW: begin
				nxt_rdata = {nonpref_top, `RSVD_NIBBLE, nonpref_bottom, `RSVD_NIBBLE}; // [R13]
			end
			// Prefetchable low parts with the 64-bit code below each.
			`OFS_PREF_WINDOW_LOW: begin
				nxt_rdata = {pref_top_low, `CAP64_CODE, pref_bottom_low, `CAP64_CODE}; // [R04]
			end
			// Upper half of the prefetchable bottom.
			`OFS_PREF_BOTTOM_HI: begin
				nxt_rdata = pref_bottom_high; // [R08]
			end
			// Upper half of the prefetchable top.
			`OFS_PREF_TOP_HI: begin
				nxt_rdata = pref_top_high; // [R09]
			end
			// Upper I/O bounds, top above bottom.
			`OFS_IO_WINDOW_HI: begin
				nxt_rdata = {io_top_high, io_bottom_high}; // [R11]
			end
			// Unmapped offsets read zero.
			default: begin
				nxt_rdata = `READ_IDLE;
			end
		endcase
	end

	// Read data stand only in the cycle after the strobe and fall back to zero, which keeps stale words off the bus.
	// A read strobed together with a write of the same word would see the old value.
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rdata_ff <= `READ_IDLE;
		end else if (reg_rd_in) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= `READ_IDLE;
		end
	end

	// Every output comes straight from a flip-flop, so downstream logic never sees decode glitches.
	assign reg_rdata_out   = rdata_ff;
	assign qry_done_out    = qry_done_ff;
	assign hit_nonpref_out = hit_nonpref_ff;
	assign hit_pref_out    = hit_pref_ff;
	assign hit_io_out      = hit_io_ff;
	assign forward_out     = forward_ff;

endmodule // bridge_memory_window_regs

/* src/bridge_window_defs.svh */
// Offsets, field positions, reset values and constant codes of the bridge memory and I/O window registers.
// Assumes byte addresses on the register port, one aligned 32-bit word per register.
`ifndef BRIDGE_WINDOW_DEFS_SVH
`define BRIDGE_WINDOW_DEFS_SVH

// Register byte offsets.
`define OFS_MEM_WINDOW      8'h20
`define OFS_PREF_WINDOW_LOW 8'h24
`define OFS_PREF_BOTTOM_HI  8'h28
`define OFS_PREF_TOP_HI     8'h2C
`define OFS_IO_WINDOW_HI    8'h30
`define REG_ADDR_W          8

// Field positions inside the 32-bit words.
`define BASE_FIELD_LSB      4
`define BASE_FIELD_MSB      15
`define LIMIT_FIELD_LSB     20
`define LIMIT_FIELD_MSB     31
`define IO_BOTTOM_LSB       0
`define IO_BOTTOM_MSB       15
`define IO_TOP_LSB          16
`define IO_TOP_MSB          31

// Field widths.
`define MEM_FIELD_W         12
`define HIGH_WORD_W         32
`define IO_FIELD_W          16

// Reset values.
`define RST_MEM_FIELD       12'h000
`define RST_HIGH_WORD       32'h00000000
`define RST_IO_FIELD        16'h0000

// Constant codes and implied low address bits.
`define CAP64_CODE          4'h1
`define RSVD_NIBBLE         4'h0
`define LOW20_BOTTOM        20'h00000
`define LOW20_TOP           20'hFFFFF
`define UPPER32_ZERO        32'h00000000
`define READ_IDLE           32'h00000000

`endif

/* src/bridge_window_pkg.sv */
// Types shared by the bridge window register bank and its helpers.
// Assumes the constants come from bridge_window_defs.svh.
package bridge_window_pkg;

	// Address space of a decode query.
	typedef enum logic [0:0] {
		SPACE_MEMORY = 1'h0,
		SPACE_IO     = 1'h1
	} space_t;

	// Full 64-bit transaction address.
	typedef logic [63:0] bus_addr_t;

	// Register port data word.
	typedef logic [31:0] reg_word_t;

endpackage

/* src/window_field.sv */
// One writable field of the window register bank, loaded whole on a write strobe.
// Assumes a synchronous active-high reset on the same clock as the strobe.
`timescale 1ns/10ps

module window_field #(
	parameter int          WIDTH     = 12,
	parameter logic [WIDTH-1:0] RST_VALUE = '0
) (
	input  wire logic             core_clk_in,
	input  wire logic             rst_in,
	input  wire logic             load_in,
	input  wire logic [WIDTH-1:0] data_in,
	output logic      [WIDTH-1:0] value_out
);

	logic [WIDTH-1:0] value_ff;

	// The field keeps its value until software writes the word that holds it.
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			value_ff <= RST_VALUE;
		end else if (load_in) begin
			value_ff <= data_in;
		end
	end

	assign value_out = value_ff;

endmodule // window_field

/* src/window_compare.sv */
// Inclusive range check of an address against an expanded window bottom and top.
// Assumes bottom and top are already widened with their implied low bits.
`timescale 1ns/10ps

module window_compare #(
	parameter int WIDTH = 32
) (
	input  wire logic [WIDTH-1:0] addr_in,
	input  wire logic [WIDTH-1:0] bottom_in,
	input  wire logic [WIDTH-1:0] top_in,
	output logic                  inside_out
);

	// A window whose bottom lies above its top matches nothing, which is how software disables it.
	assign inside_out = (addr_in >= bottom_in) && (addr_in <= top_in); // [R12]

endmodule // window_compare

/* tb/bridge_memory_window_regs_checker.sv */
// Concurrent checks on the ports of the bridge window register bank.
// Assumes it is attached to the bank by the bind at the foot of this file.
`timescale 1ns/10ps
`include "bridge_window_defs.svh"

module bridge_window_checker (
	input wire logic                   core_clk_in,
	input wire logic                   rst_in,
	input wire logic [`REG_ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0]            reg_wdata_in,
	input wire logic                   reg_wr_in,
	input wire logic                   reg_rd_in,
	input wire logic [31:0]            reg_rdata_out,
	input wire logic                   qry_valid_in,
	input wire logic                   qry_space_in,
	input wire logic                   qry_from_secondary_in,
	input wire logic [63:0]            qry_addr_in,
	input wire logic                   qry_done_out,
	input wire logic                   hit_nonpref_out,
	input wire logic                   hit_pref_out,
	input wire logic                   hit_io_out,
	input wire logic                   forward_out
);
	// All checks live in the single clock domain and pause during reset.
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	// Fixed nibbles of the two memory window words.
	AST_RSVD_MEM: assert property (reg_rd_in && reg_addr_in == `OFS_MEM_WINDOW |=>
		reg_rdata_out[3:0] == 4'h0 && reg_rdata_out[19:16] == 4'h0) else $error("reserved nibble not zero");
	AST_CAP64: assert property (reg_rd_in && reg_addr_in == `OFS_PREF_WINDOW_LOW |=>
		reg_rdata_out[3:0] == 4'h1 && reg_rdata_out[19:16] == 4'h1) else $error("capability nibble wrong");
	// A write to either prefetchable upper word or the I/O word, followed at once by a read of it, returns the written value.
	AST_BOTTOM_HI_RW: assert property ((reg_wr_in && reg_addr_in == `OFS_PREF_BOTTOM_HI) ##1
		(reg_rd_in && reg_addr_in == `OFS_PREF_BOTTOM_HI) |=> reg_rdata_out == $past(reg_wdata_in, 2))
		else $error("bottom upper word lost");
	AST_TOP_HI_RW: assert property ((reg_wr_in && reg_addr_in == `OFS_PREF_TOP_HI) ##1
		(reg_rd_in && reg_addr_in == `OFS_PREF_TOP_HI) |=> reg_rdata_out == $past(reg_wdata_in, 2))
		else $error("top upper word lost");
	AST_IO_RW: assert property ((reg_wr_in && reg_addr_in == `OFS_IO_WINDOW_HI) ##1
		(reg_rd_in && reg_addr_in == `OFS_IO_WINDOW_HI) |=> reg_rdata_out == $past(reg_wdata_in, 2))
		else $error("io word lost");
	// Query answers come one cycle later and hold until the next query.
	AST_QRY_ANSWER: assert property (qry_done_out == $past(qry_valid_in)) else $error("query answer late");
	AST_HIT_HOLD: assert property (!qry_valid_in |=>
		$stable({hit_nonpref_out, hit_pref_out, hit_io_out, forward_out})) else $error("decode result moved");
	AST_SPACE_SPLIT: assert property (qry_valid_in && qry_space_in |=>
		!hit_nonpref_out && !hit_pref_out) else $error("memory window hit by io query");
	AST_FWD_DIR: assert property (qry_valid_in |=> forward_out ==
		((hit_nonpref_out || hit_pref_out || hit_io_out) != $past(qry_from_secondary_in)))
		else $error("forward decision wrong");
	AST_NONPREF_32: assert property (qry_valid_in && qry_addr_in[63:32] != 32'h0 |=>
		!hit_nonpref_out) else $error("32-bit window hit above 4G");
endmodule // bridge_window_checker

bind bridge_memory_window_regs bridge_window_checker i_bridge_window_checker (
	.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
	.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.qry_valid_in(qry_valid_in), .qry_space_in(qry_space_in), .qry_from_secondary_in(qry_from_secondary_in),
	.qry_addr_in(qry_addr_in), .qry_done_out(qry_done_out), .hit_nonpref_out(hit_nonpref_out),
	.hit_pref_out(hit_pref_out), .hit_io_out(hit_io_out), .forward_out(forward_out)
);

/* tb/pci_agent_model.sv */
// Behavioural model of the bus agents that present decode queries to the window bank.
// Assumes the bank answers a query one cycle after the edge that takes it.
`timescale 1ns/10ps

module pci_agent_model (
	input  wire logic        core_clk_in,
	input  wire logic        qry_done_in,
	output logic             qry_valid_out,
	output logic             qry_space_out,
	output logic             qry_from_secondary_out,
	output logic      [63:0] qry_addr_out
);
	// Idle at time zero so the bank sees no query before reset ends.
	initial begin
		qry_valid_out <= 1'h0;
		qry_space_out <= 1'h0;
		qry_from_secondary_out <= 1'h0;
		qry_addr_out <= 64'h0;
	end

	// One query for one cycle; the address is then inverted so no stale value lingers.
	task automatic issue(input logic [1:0] kind, input logic [63:0] a, output logic done);
		@(posedge core_clk_in);
		qry_valid_out <= 1'h1;
		qry_space_out <= kind[1];
		qry_from_secondary_out <= kind[0];
		qry_addr_out <= a;
		@(posedge core_clk_in);
		qry_valid_out <= 1'h0;
		qry_addr_out <= ~a;
		#1 done = qry_done_in;
	endtask
endmodule // pci_agent_model

/* tb/test_bridge_memory_window_regs.sv */
// Self-checking bench for the bridge window register bank.
// Assumes the bank, its checker and the agent model are compiled beforehand.
`timescale 1ns/10ps
`include "bridge_window_defs.svh"

module test_bridge_memory_window_regs;
	logic        core_clk_in;
	logic        rst_in;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        wr;
	logic        rd;
	logic        qv;
	logic        qs;
	logic        qd;
	logic [63:0] qa;
	logic        done;
	logic        nonpref;
	logic        pref;
	logic        io;
	logic        fwd;
	int          err_total = 0;
	int          n_tests = 0;

	bridge_memory_window_regs i_bridge_memory_window_regs (.core_clk_in(core_clk_in), .rst_in(rst_in),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.qry_valid_in(qv), .qry_space_in(qs), .qry_from_secondary_in(qd), .qry_addr_in(qa),
		.qry_done_out(done), .hit_nonpref_out(nonpref), .hit_pref_out(pref), .hit_io_out(io), .forward_out(fwd));
	pci_agent_model i_pci_agent_model (.core_clk_in(core_clk_in), .qry_done_in(done), .qry_valid_out(qv),
		.qry_space_out(qs), .qry_from_secondary_out(qd), .qry_addr_out(qa));

	// Free-running 250 MHz clock.
	initial begin
		core_clk_in = 1'h0;
		forever #2 core_clk_in = ~core_clk_in;
	end

	// Compares one value and counts it; unknowns never match.
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Holds reset for five edges and releases it just after an edge.
	task automatic do_reset();
		rst_in <= 1'h1;
		repeat (5) @(posedge core_clk_in);
		rst_in <= 1'h0;
	endtask

	// Single read strobe; data are looked at in the one cycle they stand.
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk_in);
		addr <= a;
		rd <= 1'h1;
		@(posedge core_clk_in);
		rd <= 1'h0;
		#1 check("read", rdata, exp);
	endtask

	// Write strobe followed with no gap by a read of the same word.
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
		@(posedge core_clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge core_clk_in);
		wr <= 1'h0;
		rd <= 1'h1;
		@(posedge core_clk_in);
		rd <= 1'h0;
		#1 check("readback", rdata, exp);
	endtask

	// Query through the agent model; expected bits are nonpref, pref, io, forward.
	task automatic q(input logic [1:0] kind, input logic [63:0] a, input logic [3:0] exp);
		logic got;
		i_pci_agent_model.issue(kind, a, got);
		check("query", {27'h0, got, nonpref, pref, io, fwd}, {27'h0, 1'h1, exp});
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Cuts a hang short well after the hundred or so cycles the tests need.
	initial begin
		repeat (3000) @(posedge core_clk_in);
		err_total++;
		end_sim();
	end

	// Main sequence: reset values, field masks, window decode, reset in mid-run.
	initial begin
		{addr, wdata, wr, rd} <= '0;
		do_reset();
		rd_chk(`OFS_MEM_WINDOW, 32'h00000000);
		rd_chk(`OFS_PREF_WINDOW_LOW, 32'h00010001);
		rd_chk(`OFS_PREF_BOTTOM_HI, 32'h00000000);
		rd_chk(`OFS_PREF_TOP_HI, 32'h00000000);
		rd_chk(`OFS_IO_WINDOW_HI, 32'h00000000);
		wr_chk(8'h34, 32'hFFFFFFFF, 32'h00000000);
		wr_chk(`OFS_MEM_WINDOW, 32'hFFFFFFFF, 32'hFFF0FFF0);
		wr_chk(`OFS_PREF_WINDOW_LOW, 32'hFFFFFFFF, 32'hFFF1FFF1);
		wr_chk(`OFS_PREF_WINDOW_LOW, 32'h00000000, 32'h00010001);
		wr_chk(`OFS_IO_WINDOW_HI, 32'hA55A5AA5, 32'hA55A5AA5);
		// Windows: 32-bit 0x10000000..0x123FFFFF, 64-bit 4G..8G-1, io upper 0x0001..0x0002.
		wr_chk(`OFS_MEM_WINDOW, 32'h12301000, 32'h12301000);
		wr_chk(`OFS_PREF_WINDOW_LOW, 32'hFFF00000, 32'hFFF10001);
		wr_chk(`OFS_PREF_BOTTOM_HI, 32'h00000001, 32'h00000001);
		wr_chk(`OFS_PREF_TOP_HI, 32'h00000001, 32'h00000001);
		wr_chk(`OFS_IO_WINDOW_HI, 32'h00020001, 32'h00020001);
		q(2'h0, 64'h0000000010000000, 4'h9);
		q(2'h0, 64'h000000000FFFFFFF, 4'h0);
		q(2'h0, 64'h00000000123FFFFF, 4'h9);
		q(2'h0, 64'h0000000012400000, 4'h0);
		q(2'h1, 64'h0000000012400000, 4'h1);
		q(2'h1, 64'h0000000010000000, 4'h8);
		q(2'h0, 64'h0000000100000000, 4'h5);
		q(2'h0, 64'h00000000FFFFFFFF, 4'h0);
		q(2'h0, 64'h00000001FFFFFFFF, 4'h5);
		q(2'h0, 64'h0000000200000000, 4'h0);
		q(2'h0, 64'h0000000110000000, 4'h5);
		q(2'h2, 64'h0000000000010000, 4'h3);
		q(2'h2, 64'h000000000002FFFF, 4'h3);
		q(2'h2, 64'h0000000000030000, 4'h0);
		q(2'h2, 64'h000000000000FFFF, 4'h0);
		q(2'h3, 64'h0000000010000000, 4'h1);
		// A reset in mid-run must clear every field again.
		@(posedge core_clk_in);
		do_reset();
		rd_chk(`OFS_MEM_WINDOW, 32'h00000000);
		rd_chk(`OFS_PREF_WINDOW_LOW, 32'h00010001);
		rd_chk(`OFS_PREF_BOTTOM_HI, 32'h00000000);
		rd_chk(`OFS_PREF_TOP_HI, 32'h00000000);
		rd_chk(`OFS_IO_WINDOW_HI, 32'h00000000);
		end_sim();
	end
endmodule // test_bridge_memory_window_regs
